// file: include/aac_pkg.sv
// Shared constants and types for the axis auxiliary command handler
package aac_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int AXIS_COUNT = 2;
	localparam int IRQ_W      = 4;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CMD_ADDR   = 8'h00;
	localparam logic [7:0] REG_CMD_VALUE  = 8'h04;
	localparam logic [7:0] REG_CMD_ISSUE  = 8'h08;
	localparam logic [7:0] REG_CMD_RESULT = 8'h0c;
	localparam logic [7:0] REG_JOG_SPEED  = 8'h10;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
	localparam logic [7:0] REG_IRQ_CLEAR  = 8'h18;
	localparam logic [7:0] REG_IRQ_ENABLE = 8'h1c;
	localparam logic [7:0] REG_STATE_SNAP = 8'h40;
	localparam logic [3:0] AX_PAGE_BASE   = 4'h2;
	localparam logic [3:0] AX_OFF_STATE   = 4'h0;
	localparam logic [3:0] AX_OFF_POS     = 4'h4;
	localparam logic [3:0] AX_OFF_STEP    = 4'h8;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CMD_SLOT_LSB  = 16;
	localparam int ST_AUXNUM_LSB = 16;
	localparam int RES_OP_LSB    = 4;
	localparam int IRQ_DONE      = 0;
	localparam int IRQ_REJECT    = 1;
	localparam int IRQ_JOG_END   = 2;
	localparam int IRQ_AUX_CODE  = 3;

	// ------------------------------------------------------------
	// Values and reset values
	// ------------------------------------------------------------
	localparam logic [15:0]      SLOT_NUM        = 16'h0000;
	localparam logic [15:0]      AXIS_MAX        = 16'h0001;
	localparam logic [15:0]      START_STEP_MIN  = 16'h0001;
	localparam logic [15:0]      STEP_MAX        = 16'h0096;
	localparam logic [7:0]       RST_START_STEP  = 8'h01;
	localparam logic [7:0]       RST_REPEAT_STEP = 8'h00;
	localparam logic [15:0]      RST_JOG_SPEED   = 16'h0010;
	localparam logic [IRQ_W-1:0] RST_IRQ_EN      = 4'h0;

	// ------------------------------------------------------------
	// Commands and reject reasons
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		op_nop                        = 4'h0,
		op_jog_move_cmd               = 4'h1,
		op_jog_move_cmd_alt           = 4'h2,
		op_start_step_change_cmd      = 4'h3,
		op_repeat_step_change_cmd     = 4'h4,
		op_repeat_step_change_cmd_alt = 4'h5,
		op_aux_code_release_cmd       = 4'h6,
		op_position_preset_cmd        = 4'h7,
		op_error_reset                = 4'h8,
		op_axis_state_read_cmd        = 4'h9
	} aac_op_t;

	typedef enum logic [2:0] {
		rsn_ok     = 3'h0,
		rsn_opcode = 3'h1,
		rsn_slot   = 3'h2,
		rsn_axis   = 3'h3,
		rsn_busy   = 3'h4,
		rsn_error  = 3'h5,
		rsn_range  = 3'h6
	} aac_rsn_t;

endpackage

// file: include/aac_axis_if.sv
// Command and state link between the handler and one axis
`timescale 1ns/1ps
interface aac_axis_if;
	import aac_pkg::*;
	logic        go;
	logic        fail;
	aac_op_t     op;
	logic [31:0] value;
	logic [15:0] jog_speed;
	logic        aux_set;
	logic [15:0] aux_set_num;
	logic        busy;
	logic        error;
	logic        origin;
	logic        aux_flag;
	logic [15:0] aux_num;
	logic [31:0] pos;
	logic [7:0]  start_step;
	logic [7:0]  repeat_step;
	logic        jog_done;
	logic        step;
	logic        dir;

	modport ctl (
		output go, fail, op, value, jog_speed, aux_set, aux_set_num,
		input  busy, error, origin, aux_flag, aux_num, pos, start_step, repeat_step, jog_done, step, dir
	);
	modport ax (
		input  go, fail, op, value, jog_speed, aux_set, aux_set_num,
		output busy, error, origin, aux_flag, aux_num, pos, start_step, repeat_step, jog_done, step, dir
	);
endinterface

// file: src/aac_axis.sv
// Per-axis state: position, origin, steps, pending auxiliary code and jog engine
`timescale 1ns/1ps
module aac_axis
	import aac_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Link to the handler
	aac_axis_if.ax   ax
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [31:0] pos_q;
	logic        org_q;
	logic [7:0]  start_q;
	logic [7:0]  rep_q;
	logic        auxf_q;
	logic [15:0] auxn_q;
	logic        err_q;
	logic        busy_q;
	logic        dir_q;
	logic [31:0] rem_q;
	logic [15:0] cnt_q;
	logic        step_q;
	logic        done_q;

	// Command decode; the handler only sends commands it has accepted
	wire         jog_go   = ax.go && (ax.op == op_jog_move_cmd || ax.op == op_jog_move_cmd_alt);
	wire         pre_go   = ax.go && (ax.op == op_position_preset_cmd);
	wire         start_go = ax.go && (ax.op == op_start_step_change_cmd);
	wire         rep_go   = ax.go && (ax.op == op_repeat_step_change_cmd || ax.op == op_repeat_step_change_cmd_alt);
	wire         rel_go   = ax.go && (ax.op == op_aux_code_release_cmd);
	wire         erst_go  = ax.go && (ax.op == op_error_reset);
	// Signed distance becomes a direction and a magnitude
	wire [31:0]  jog_mag  = ax.value[31] ? (32'h0000_0000 - ax.value) : ax.value;
	// A speed of zero would never tick, so it is treated as one cycle per count
	wire [15:0]  spd_m1   = (ax.jog_speed == 16'h0000) ? 16'h0000 : (ax.jog_speed - 16'h0001);
	wire         tick     = busy_q && (cnt_q == 16'h0000);
	wire         last     = tick && (rem_q == 32'h0000_0001);

	// Jog engine: one count per tick at the jog speed
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
			dir_q  <= 1'b0;
			rem_q  <= 32'h0000_0000;
			cnt_q  <= 16'h0000;
		end else if (jog_go) begin
			busy_q <= (jog_mag != 32'h0000_0000);
			dir_q  <= ax.value[31];
			rem_q  <= jog_mag;
			cnt_q  <= spd_m1;
		end else if (tick) begin
			busy_q <= !last;
			rem_q  <= rem_q - 32'h0000_0001;
			cnt_q  <= spd_m1;
		end else if (busy_q) begin
			cnt_q  <= cnt_q - 16'h0001;
		end
	end

	// Step strobe and end-of-jog pulse
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			step_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			step_q <= tick;
			done_q <= last || (jog_go && jog_mag == 32'h0000_0000);
		end
	end

	// Position and origin; preset is refused while moving, and wins over a tick that falls in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pos_q <= 32'h0000_0000;
			org_q <= 1'b0;
		end else if (pre_go) begin
			pos_q <= ax.value;
			org_q <= 1'b1;
		end else if (tick) begin
			pos_q <= dir_q ? (pos_q - 32'h0000_0001) : (pos_q + 32'h0000_0001);
		end
	end

	// Step numbers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			start_q <= RST_START_STEP;
			rep_q   <= RST_REPEAT_STEP;
		end else begin
			if (start_go)
				start_q <= ax.value[7:0];
			if (rep_go)
				rep_q   <= ax.value[7:0];
		end
	end

	// Pending code and error; a new code or a fault wins over a same-cycle clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			auxf_q <= 1'b0;
			auxn_q <= 16'h0000;
			err_q  <= 1'b0;
		end else begin
			if (ax.aux_set) begin
				auxf_q <= 1'b1;
				auxn_q <= ax.aux_set_num;
			end else if (rel_go && auxf_q) begin
				auxf_q <= 1'b0;
				auxn_q <= 16'h0000;
			end
			err_q <= ax.fail || (err_q && !erst_go);
		end
	end

	// State back to the handler
	assign ax.busy        = busy_q;
	assign ax.error       = err_q;
	assign ax.aux_flag    = auxf_q;
	assign ax.origin      = org_q;
	assign ax.aux_num     = auxn_q;
	assign ax.pos         = pos_q;
	assign ax.start_step  = start_q;
	assign ax.repeat_step = rep_q;
	assign ax.jog_done    = done_q;
	assign ax.step        = step_q;
	assign ax.dir         = dir_q;

endmodule

// file: src/aac_handler.sv
// Auxiliary per-axis command handler with register port and interrupt
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module aac_handler
	import aac_pkg::*;
(
	// Clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	// Register port
	input  wire logic [7:0]                  reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [31:0]                 reg_rdata,
	// Interrupt
	output logic                             irq,
	// Pending auxiliary codes from the motion sequencer
	input  wire logic [AXIS_COUNT-1:0]       aux_code_set,
	input  wire logic [AXIS_COUNT-1:0][15:0] aux_code_num,
	// Axis state and step output
	output logic      [AXIS_COUNT-1:0]       axis_busy,
	output logic      [AXIS_COUNT-1:0]       axis_error,
	output logic      [AXIS_COUNT-1:0]       move_step,
	output logic      [AXIS_COUNT-1:0]       move_dir
);

	// ------------------------------------------------------------
	// Registers and per-axis views
	// ------------------------------------------------------------
	logic [15:0]           cmd_axis_q;
	logic [15:0]           cmd_slot_q;
	logic [31:0]           cmd_value_q;
	logic [15:0]           jog_speed_q;
	logic [15:0]           result_q;
	logic [31:0]           snap_q;
	logic [IRQ_W-1:0]      irq_st_q;
	logic [IRQ_W-1:0]      irq_en_q;
	logic                  irq_q;
	logic [31:0]           rdata_q;
	logic [AXIS_COUNT-1:0] go_q;
	logic [AXIS_COUNT-1:0] fail_q;
	aac_op_t               op_q;
	logic [31:0]           value_q;
	logic [31:0]           st_word   [AXIS_COUNT];
	logic [31:0]           pos_word  [AXIS_COUNT];
	logic [31:0]           step_word [AXIS_COUNT];
	logic [AXIS_COUNT-1:0] busy_v;
	logic [AXIS_COUNT-1:0] err_v;
	logic [AXIS_COUNT-1:0] done_v;
	logic [AXIS_COUNT-1:0] step_v;
	logic [AXIS_COUNT-1:0] dir_v;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Write strobes per register
	wire wr_cmd_addr  = reg_wr && (reg_addr == REG_CMD_ADDR);
	wire wr_cmd_value = reg_wr && (reg_addr == REG_CMD_VALUE);
	wire wr_issue     = reg_wr && (reg_addr == REG_CMD_ISSUE);
	wire wr_jog_speed = reg_wr && (reg_addr == REG_JOG_SPEED);
	wire wr_irq_clear = reg_wr && (reg_addr == REG_IRQ_CLEAR);
	wire wr_irq_en    = reg_wr && (reg_addr == REG_IRQ_ENABLE);

	// Axis pages sit one per 16 bytes above the common block
	wire [3:0] ax_page = reg_addr[7:4] - AX_PAGE_BASE;
	wire       ax_hit  = (reg_addr[7:4] >= AX_PAGE_BASE) && (ax_page < 4'(AXIS_COUNT));
	wire       ax_idx  = ax_page[0];
	wire [3:0] ax_off  = reg_addr[3:0];

	// ------------------------------------------------------------
	// Command legality
	// ------------------------------------------------------------
	// The issue write carries the opcode; slot, axis and value come from the staging registers
	aac_op_t issue_op;
	assign issue_op = aac_op_t'(reg_wdata[3:0]);

	wire        op_known = issue_op inside {op_nop, op_jog_move_cmd, op_jog_move_cmd_alt,
		op_start_step_change_cmd, op_repeat_step_change_cmd, op_repeat_step_change_cmd_alt,
		op_aux_code_release_cmd, op_position_preset_cmd, op_error_reset, op_axis_state_read_cmd};
	wire        slot_ok  = (cmd_slot_q == SLOT_NUM);
	wire        axis_ok  = (cmd_axis_q <= AXIS_MAX);
	wire        sel_axis = cmd_axis_q[0];
	wire        sel_busy = busy_v[sel_axis];
	wire        sel_err  = err_v[sel_axis];
	wire [15:0] step_arg = cmd_value_q[15:0];

	wire is_jog   = (issue_op == op_jog_move_cmd) || (issue_op == op_jog_move_cmd_alt);
	wire is_start = (issue_op == op_start_step_change_cmd);
	wire is_rep   = (issue_op == op_repeat_step_change_cmd) || (issue_op == op_repeat_step_change_cmd_alt);
	wire is_pre   = (issue_op == op_position_preset_cmd);
	wire is_read  = (issue_op == op_axis_state_read_cmd);

	// Out-of-range step numbers are refused rather than clipped, so a bad host value never lands
	wire start_in_range = (step_arg >= START_STEP_MIN) && (step_arg <= STEP_MAX);
	wire rep_in_range   = (step_arg <= STEP_MAX);
	// Only jog, start step change and preset wait for the axis to stop; release and repeat do not
	wire busy_block = (is_jog || is_start || is_pre) && sel_busy;
	wire err_block  = is_jog && sel_err;
	wire range_bad  = (is_start && !start_in_range) || (is_rep && !rep_in_range);

	// First failing check names the reason
	aac_rsn_t issue_rsn;
	assign issue_rsn = !op_known  ? rsn_opcode :
	                   !slot_ok   ? rsn_slot   :
	                   !axis_ok   ? rsn_axis   :
	                   err_block  ? rsn_error  :
	                   busy_block ? rsn_busy   :
	                   range_bad  ? rsn_range  : rsn_ok;

	wire issue_ok  = wr_issue && (issue_rsn == rsn_ok);
	wire issue_bad = wr_issue && (issue_rsn != rsn_ok);
	// Faults tied to a valid axis also raise that axis's error bit
	wire axis_flt  = issue_bad && (issue_rsn inside {rsn_busy, rsn_error, rsn_range});

	// ------------------------------------------------------------
	// Staging and parameter registers
	// ------------------------------------------------------------
	// Slot, axis and operand are held across issues until rewritten, so a command can be repeated
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmd_axis_q  <= 16'h0000;
			cmd_slot_q  <= 16'h0000;
			cmd_value_q <= 32'h0000_0000;
			jog_speed_q <= RST_JOG_SPEED;
		end else begin
			if (wr_cmd_addr) begin
				cmd_axis_q <= reg_wdata[CMD_SLOT_LSB-1:0];
				cmd_slot_q <= reg_wdata[31:CMD_SLOT_LSB];
			end
			if (wr_cmd_value)
				cmd_value_q <= reg_wdata;
			if (wr_jog_speed)
				jog_speed_q <= reg_wdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// Dispatch to the axes
	// ------------------------------------------------------------
	// One-cycle command pulse to the selected axis
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			go_q    <= '0;
			fail_q  <= '0;
			op_q    <= op_nop;
			value_q <= 32'h0000_0000;
		end else begin
			go_q    <= issue_ok ? (AXIS_COUNT'(1) << sel_axis) : '0;
			fail_q  <= axis_flt ? (AXIS_COUNT'(1) << sel_axis) : '0;
			op_q    <= issue_op;
			value_q <= cmd_value_q;
		end
	end

	// Last command outcome and the latched axis state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			result_q <= 16'h0000;
			snap_q   <= 32'h0000_0000;
		end else if (wr_issue) begin
			result_q <= {5'h00, issue_rsn, reg_wdata[3:0], 2'b00, issue_bad, issue_ok};
			if (issue_ok && is_read)
				snap_q <= st_word[sel_axis];
		end
	end

	// ------------------------------------------------------------
	// Axes
	// ------------------------------------------------------------
	aac_axis_if ax_if[AXIS_COUNT] ();

	genvar gi;
	generate
		for (gi = 0; gi < AXIS_COUNT; gi++) begin : g_axis
			assign ax_if[gi].go          = go_q[gi];
			assign ax_if[gi].fail        = fail_q[gi];
			assign ax_if[gi].op          = op_q;
			assign ax_if[gi].value       = value_q;
			assign ax_if[gi].jog_speed   = jog_speed_q;
			assign ax_if[gi].aux_set     = aux_code_set[gi];
			assign ax_if[gi].aux_set_num = aux_code_num[gi];

			// Readable views of the axis state
			assign st_word[gi]   = {ax_if[gi].aux_num, {(ST_AUXNUM_LSB-4){1'b0}}, ax_if[gi].aux_flag,
			                        ax_if[gi].origin, ax_if[gi].error, ax_if[gi].busy};
			assign pos_word[gi]  = ax_if[gi].pos;
			assign step_word[gi] = {16'h0000, ax_if[gi].repeat_step, ax_if[gi].start_step};
			assign busy_v[gi]    = ax_if[gi].busy;
			assign err_v[gi]     = ax_if[gi].error;
			assign done_v[gi]    = ax_if[gi].jog_done;
			assign step_v[gi]    = ax_if[gi].step;
			assign dir_v[gi]     = ax_if[gi].dir;

			aac_axis u_axis (
				.sys_clk (sys_clk),
				.rst     (rst),
				.ax      (ax_if[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	// Events of this cycle; a set beats a clear of the same bit
	wire [IRQ_W-1:0] irq_ev  = {|aux_code_set, |done_v, issue_bad, issue_ok};
	wire [IRQ_W-1:0] irq_clr = wr_irq_clear ? reg_wdata[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0] irq_st_d = (irq_st_q & ~irq_clr) | irq_ev;
	wire [IRQ_W-1:0] irq_en_d = wr_irq_en ? reg_wdata[IRQ_W-1:0] : irq_en_q;

	// Sticky status, enable and the level output
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_st_q <= '0;
			irq_en_q <= RST_IRQ_EN;
			irq_q    <= 1'b0;
		end else begin
			irq_st_q <= irq_st_d;
			irq_en_q <= irq_en_d;
			irq_q    <= |(irq_st_d & irq_en_d);
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Unmapped and write-only offsets read as zero
	wire [31:0] ax_rdata = (ax_off == AX_OFF_STATE) ? st_word[ax_idx]   :
	                       (ax_off == AX_OFF_POS)   ? pos_word[ax_idx]  :
	                       (ax_off == AX_OFF_STEP)  ? step_word[ax_idx] : 32'h0000_0000;
	wire [31:0] rdata_d  = (reg_addr == REG_CMD_ADDR)   ? {cmd_slot_q, cmd_axis_q}     :
	                       (reg_addr == REG_CMD_VALUE)  ? cmd_value_q                  :
	                       (reg_addr == REG_CMD_RESULT) ? {16'h0000, result_q}         :
	                       (reg_addr == REG_JOG_SPEED)  ? {16'h0000, jog_speed_q}      :
	                       (reg_addr == REG_IRQ_STATUS) ? {28'h0000000, irq_st_q}      :
	                       (reg_addr == REG_IRQ_ENABLE) ? {28'h0000000, irq_en_q}      :
	                       (reg_addr == REG_STATE_SNAP) ? snap_q                       :
	                       ax_hit                       ? ax_rdata                     : 32'h0000_0000;

	// Read data stand for exactly the one cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			rdata_q <= 32'h0000_0000;
		else
			rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// All of these come from flip-flops here or inside the axes
	assign reg_rdata  = rdata_q;
	assign irq        = irq_q;
	assign axis_busy  = busy_v;
	assign axis_error = err_v;
	assign move_step  = step_v;
	assign move_dir   = dir_v;

endmodule

// file: tb/aac_handler_properties.sv
// Port-level assertions for the auxiliary command handler
`timescale 1ns/1ps
module aac_handler_checker
	import aac_pkg::*;
(
	// Clock, reset and register port
	input wire logic                        sys_clk,
	input wire logic                        rst,
	input wire logic [7:0]                  reg_addr,
	input wire logic [31:0]                 reg_wdata,
	input wire logic                        reg_wr,
	input wire logic                        reg_rd,
	input wire logic [31:0]                 reg_rdata,
	input wire logic                        irq,
	// Axis side
	input wire logic [AXIS_COUNT-1:0]       aux_code_set,
	input wire logic [AXIS_COUNT-1:0][15:0] aux_code_num,
	input wire logic [AXIS_COUNT-1:0]       axis_busy,
	input wire logic [AXIS_COUNT-1:0]       axis_error,
	input wire logic [AXIS_COUNT-1:0]       move_step,
	input wire logic [AXIS_COUNT-1:0]       move_dir
);
	logic iss_q;
	logic en_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Shadow of issue strobes and enables: a change of axis state or irq must trace back to one
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			iss_q <= 1'b0;
			en_q  <= 1'b0;
		end else begin
			iss_q <= reg_wr && (reg_addr == REG_CMD_ISSUE);
			if (reg_wr && (reg_addr == REG_IRQ_ENABLE)) begin
				en_q <= |reg_wdata[IRQ_W-1:0];
			end
		end
	end
	a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its slot");
	a_step_in_jog0: assert property (move_step[0] |-> $past(axis_busy[0]))
		else $error("axis 0 step without a jog");
	a_step_in_jog1: assert property (move_step[1] |-> $past(axis_busy[1]))
		else $error("axis 1 step without a jog");
	a_dir_hold_jog: assert property (axis_busy[0] && $past(axis_busy[0]) |-> $stable(move_dir[0]))
		else $error("direction changed during a jog");
	a_busy_from_issue0: assert property ($rose(axis_busy[0]) |-> iss_q || $past(iss_q) || $past(iss_q, 2))
		else $error("axis 0 started without a command");
	a_busy_from_issue1: assert property ($rose(axis_busy[1]) |-> iss_q || $past(iss_q) || $past(iss_q, 2))
		else $error("axis 1 started without a command");
	a_error_from_issue: assert property ($rose(axis_error[0]) || $rose(axis_error[1])
		|-> iss_q || $past(iss_q) || $past(iss_q, 2))
		else $error("axis error without a refused command");
	a_irq_needs_enable: assert property (irq |-> en_q || $past(en_q))
		else $error("interrupt with no source enabled");
endmodule
bind aac_handler aac_handler_checker u_chk (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
	.aux_code_set(aux_code_set), .aux_code_num(aux_code_num), .axis_busy(axis_busy),
	.axis_error(axis_error), .move_step(move_step), .move_dir(move_dir));

// file: tb/aac_seq_model.sv
// Behavioural motion sequencer that raises pending auxiliary codes
`timescale 1ns/1ps
module aac_seq_model
	import aac_pkg::*;
(
	// Clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	// Requests from the bench
	input  wire logic [AXIS_COUNT-1:0]       fire,
	input  wire logic [15:0]                 num,
	// Toward the handler
	output logic      [AXIS_COUNT-1:0]       aux_code_set,
	output logic      [AXIS_COUNT-1:0][15:0] aux_code_num
);
	logic [15:0] num_q;
	// Outside a set pulse the number toggles, so a handler sampling it late reads garbage
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aux_code_set <= 2'h0;
			num_q        <= 16'h0;
		end else begin
			aux_code_set <= fire;
			num_q        <= (|fire) ? num : ~num_q;
		end
	end
	assign aux_code_num = {num_q, num_q};
endmodule

// file: tb/tb_aac_handler.sv
// Self-checking bench for the auxiliary command handler
`timescale 1ns/1ps
module tb_aac_handler;
	import aac_pkg::*;
	logic                        sys_clk   = 1'b0;
	logic                        rst       = 1'b1;
	logic [7:0]                  reg_addr  = 8'h00;
	logic [31:0]                 reg_wdata = 32'h0;
	logic                        reg_wr    = 1'b0;
	logic                        reg_rd    = 1'b0;
	logic                        rd_d      = 1'b0;
	logic [1:0]                  fire      = 2'h0;
	logic [15:0]                 fire_num  = 16'h0;
	logic [7:0]                  rnd       = 8'h0e;
	logic [31:0]                 reg_rdata, pv;
	logic                        irq;
	logic [AXIS_COUNT-1:0]       aux_code_set, axis_busy, axis_error, move_step, move_dir;
	logic [AXIS_COUNT-1:0][15:0] aux_code_num;
	logic [31:0]                 exp_q[$];
	int                          n_fail = 0, cmp_count = 0, n_step = 0, i;
	aac_handler dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .aux_code_set(aux_code_set), .aux_code_num(aux_code_num),
		.axis_busy(axis_busy), .axis_error(axis_error), .move_step(move_step), .move_dir(move_dir));
	aac_seq_model seq (.sys_clk(sys_clk), .rst(rst), .fire(fire), .num(fire_num), .aux_code_set(aux_code_set),
		.aux_code_num(aux_code_num));
	always #25 sys_clk = ~sys_clk;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] ax(input int n, input logic [3:0] off);
		return {AX_PAGE_BASE + 4'(n), off};
	endfunction
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t output %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// The expected word is noted when the strobe goes out and taken off when the data stand
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask
	task automatic cmd(input logic [31:0] ad, input aac_op_t op, input logic [31:0] v, input aac_rsn_t r);
		wr(REG_CMD_ADDR, ad);
		wr(REG_CMD_VALUE, v);
		wr(REG_CMD_ISSUE, {28'h0, op});
		rd(REG_CMD_RESULT, {21'h0, r, op, 2'h0, r != rsn_ok, r == rsn_ok});
	endtask
	task automatic print_verdict;
		if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe; steps of axis 0 are counted here too
	always @(posedge sys_clk) begin
		if (rd_d) chk_word(reg_rdata, exp_q.pop_front());
		rd_d <= reg_rd;
		if (move_step[0] === 1'b1) n_step++;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_fail++;
		print_verdict;
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		rd(REG_JOG_SPEED, {16'h0, RST_JOG_SPEED});
		rd(ax(0, AX_OFF_STEP), {16'h0, RST_REPEAT_STEP, RST_START_STEP});
		rd(ax(1, AX_OFF_STATE), 32'h0);
		rd(REG_CMD_ISSUE, 32'h0);
		rd(8'hfc, 32'h0);
		cmd(32'h0, op_start_step_change_cmd, 32'h96, rsn_ok);
		cmd(32'h0, op_start_step_change_cmd, 32'h0, rsn_range);
		cmd(32'h0, op_start_step_change_cmd, 32'h97, rsn_range);
		cmd(32'h0, op_repeat_step_change_cmd, 32'h0, rsn_ok);
		cmd(32'h0, op_repeat_step_change_cmd_alt, 32'h96, rsn_ok);
		cmd(32'h0, op_repeat_step_change_cmd, 32'h97, rsn_range);
		rd(ax(0, AX_OFF_STEP), 32'h9696);
		cmd(32'h0001_0000, op_axis_state_read_cmd, 32'h0, rsn_slot);
		cmd(32'h2, op_axis_state_read_cmd, 32'h0, rsn_axis);
		cmd(32'h0, aac_op_t'(4'hf), 32'h0, rsn_opcode);
		cmd(32'h0, op_nop, 32'h0, rsn_ok);
		rd(ax(0, AX_OFF_STATE), 32'h2);
		cmd(32'h0, op_error_reset, 32'h0, rsn_ok);
		rnd = lfsr(rnd);
		pv  = {{24{rnd[7]}}, rnd};
		cmd(32'h1, op_position_preset_cmd, pv, rsn_ok);
		rd(ax(1, AX_OFF_POS), pv);
		rd(ax(1, AX_OFF_STATE), 32'h4);
		// Only the code-set source is enabled, so earlier command events stay masked
		wr(REG_IRQ_ENABLE, 32'h8);
		#1 chk_bit(irq, 1'b0);
		fire     <= 2'h1;
		fire_num <= {8'h5a, rnd};
		@(posedge sys_clk);
		fire <= 2'h0;
		repeat (3) @(posedge sys_clk);
		#1 chk_bit(irq, 1'b1);
		rd(ax(0, AX_OFF_STATE), {8'h5a, rnd, 16'h8});
		wr(REG_IRQ_CLEAR, 32'h8);
		repeat (2) @(posedge sys_clk);
		#1 chk_bit(irq, 1'b0);
		rd(REG_IRQ_STATUS, 32'h3);
		rnd = lfsr(rnd);
		pv  = {{24{rnd[7]}}, rnd};
		wr(REG_JOG_SPEED, {24'h0, 8'h14 + {5'h0, rnd[2:0]}});
		cmd(32'h0, op_position_preset_cmd, pv, rsn_ok);
		cmd(32'h0, op_jog_move_cmd, 32'hffff_fffd, rsn_ok);
		#1 chk_bit(axis_busy[0], 1'b1);
		cmd(32'h0, op_start_step_change_cmd, 32'h5, rsn_busy);
		cmd(32'h0, op_repeat_step_change_cmd, {25'h0, rnd[6:0]}, rsn_ok);
		cmd(32'h0, op_aux_code_release_cmd, 32'h0, rsn_ok);
		cmd(32'h0, op_jog_move_cmd_alt, 32'h1, rsn_error);
		for (i = 0; i < 400 && axis_busy[0] !== 1'b0; i++) @(posedge sys_clk);
		#1 chk_bit(move_dir[0], 1'b1);
		chk_bit(n_step == 3, 1'b1);
		chk_bit(axis_error[0], 1'b1);
		rd(ax(0, AX_OFF_POS), pv - 32'h3);
		rd(ax(0, AX_OFF_STEP), {17'h0, rnd[6:0], 8'h96});
		rd(ax(0, AX_OFF_STATE), 32'h6);
		rd(REG_IRQ_STATUS, 32'h7);
		cmd(32'h0, op_error_reset, 32'h0, rsn_ok);
		cmd(32'h0, op_axis_state_read_cmd, 32'h0, rsn_ok);
		rd(REG_STATE_SNAP, 32'h4);
		// A short forward jog on the second axis exercises its step and busy checks
		cmd(32'h1, op_position_preset_cmd, pv, rsn_ok);
		cmd(32'h1, op_jog_move_cmd, 32'h1, rsn_ok);
		#1 chk_bit(axis_busy[1], 1'b1);
		repeat (30) @(posedge sys_clk);
		#1 chk_bit(move_dir[1], 1'b0);
		chk_bit(axis_busy[1], 1'b0);
		rd(ax(1, AX_OFF_POS), pv + 32'h1);
		repeat (3) @(posedge sys_clk);
		print_verdict;
	end
endmodule
